// ---- core/atm_cell_params.svh ----
// Named constants shared by both ends of the cell bus
`ifndef ATM_CELL_PARAMS_SVH
`define ATM_CELL_PARAMS_SVH
`define CELL_BYTES       53
`define TX_FIFO_CELLS    3
`define RX_FIFO_CELLS    3
`define LAMP_CYCLES      8'hdf  // 223 reference cycles of lamp drive
`define LINK_HALF_PERIOD 8
`define MARKER_BYTE      8'h00
`endif

// ---- core/atm_cell_pkg.sv ----
// Types and helper functions for the cell bus ends
package atm_cell_pkg;
  typedef logic [7:0] byte_t;    // One cell-bus octet
  typedef logic [4:0] port_t;    // Port address on the bus
  typedef logic [5:0] idx_t;     // Byte index inside a cell
  // Inputs the device samples from outside its clock domain
  typedef struct packed {
    logic  lref;
    logic  treq;
    logic  rx_clk;
    logic  rx_en_n;
    port_t rx_addr;
    logic  tx_clk;
    logic  tx_en_n;
    logic  tx_soc;
    logic  tx_par;
    port_t tx_addr;
    byte_t tx_data;
  } link_in_t;
  // Device outputs as the host samples them
  typedef struct packed {
    logic  tx_clav;
    logic  rx_clav;
    logic  rx_soc;
    logic  rx_par;
    byte_t rx_data;
  } phy_out_t;
  // Receive store entry: good flag rides on the first byte
  typedef struct packed {
    logic  good;
    byte_t data;
  } rx_entry_t;
  // Host transmit sequencing
  typedef enum logic [1:0] {
    HT_IDLE = 2'b01,
    HT_CELL = 2'b10
  } host_tx_state_t;
  // Odd parity bit over one octet
  function automatic logic odd_par(input byte_t b);
    return ~(^b);
  endfunction : odd_par
endpackage : atm_cell_pkg

// ---- core/atm_cell_if.sv ----
// Cell bus between the physical-layer end and the ATM-layer end
interface atm_cell_if;
  import atm_cell_pkg::*;
  logic  tx_clk;         // Transmit clock, made by the ATM layer
  port_t tx_addr;        // Transmit port address
  byte_t tx_data;        // Transmit octet
  logic  tx_soc;         // Transmit start of cell
  logic  tx_en_n;        // Transmit enable, active low
  logic  tx_parity;      // Transmit odd parity
  logic  tx_clav;        // Transmit cell available, device drive value
  logic  tx_clav_oe_n;   // Low while the device drives it
  logic  tx_clav_line;   // Resolved level
  logic  rx_clk;         // Receive clock, made by the ATM layer
  port_t rx_addr;        // Receive port address
  logic  rx_en_n;        // Receive enable, active low
  byte_t rx_data;        // Receive octet
  logic  rx_soc;         // Receive start of cell
  logic  rx_parity;      // Receive odd parity
  logic  rx_clav;        // Receive cell available, device drive value
  logic  rx_clav_oe_n;   // Low while the device drives it
  logic  rx_clav_line;   // Resolved level
  // Undriven wire reads low, as with a weak pull-down
  assign tx_clav_line = tx_clav & ~tx_clav_oe_n;
  assign rx_clav_line = rx_clav & ~rx_clav_oe_n;
  modport phy (
    input  tx_clk, tx_addr, tx_data, tx_soc, tx_en_n, tx_parity,
    input  rx_clk, rx_addr, rx_en_n,
    output tx_clav, tx_clav_oe_n, rx_data, rx_soc, rx_parity, rx_clav, rx_clav_oe_n
  );
  modport atm (
    output tx_clk, tx_addr, tx_data, tx_soc, tx_en_n, tx_parity,
    output rx_clk, rx_addr, rx_en_n,
    input  tx_clav_line, rx_clav_line, rx_data, rx_soc, rx_parity
  );
endinterface : atm_cell_if

// ---- core/phy_cell_end.sv ----
// Physical-layer end: cell stores, cell bus slave, lamps, marker and interrupt pins
`include "atm_cell_params.svh"
module phy_cell_end #(
  parameter int TX_CELLS = `TX_FIFO_CELLS,
  parameter int RX_CELLS = `RX_FIFO_CELLS
) (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rstn,
  // Cell bus toward the ATM layer
  atm_cell_if.phy                    link,
  // Configuration
  input  wire atm_cell_pkg::port_t   port_addr,
  input  wire logic [1:0]            irq_mask,
  input  wire logic                  status_read,
  input  wire logic [7:0]            marker_len,
  output logic      [1:0]            irq_status,
  // Open-drain interrupt
  output logic                       irq_o,
  output logic                       irq_oe_n,
  // Line side, transmit
  output atm_cell_pkg::byte_t        tx_line_data,
  output logic                       tx_line_soc,
  output logic                       tx_line_marker,
  output logic                       tx_line_valid,
  input  wire logic                  tx_line_ready,
  // Line side, receive
  input  wire atm_cell_pkg::byte_t   rx_line_data,
  input  wire logic                  rx_line_soc,
  input  wire logic                  rx_line_valid,
  input  wire logic                  rx_line_good,
  input  wire logic                  rx_line_marker,
  // Utility pins
  input  wire logic                  line_reference_clock,
  input  wire logic                  tx_timing_marker_request,
  output logic                       rx_activity_lamp,
  output logic                       tx_activity_lamp,
  output logic                       rx_timing_marker_pulse_n
);
  import atm_cell_pkg::*;

  localparam int TX_CAP = TX_CELLS * `CELL_BYTES;
  localparam int RX_CAP = RX_CELLS * `CELL_BYTES;
  localparam int TAW    = $clog2(TX_CAP);
  localparam int RAW    = $clog2(RX_CAP);
  localparam int CW     = $clog2(RX_CELLS + TX_CELLS + 1);
  localparam idx_t LAST = idx_t'(`CELL_BYTES - 1);

  // Stores must hold at least one whole cell
  if (TX_CELLS < 1 || RX_CELLS < 1) begin : g_bad_depth
    $error("cell store depth must be at least one cell");
  end

  // Pointer advance with wrap at store capacity
  function automatic logic [TAW-1:0] tx_next(input logic [TAW-1:0] p);
    return (p == TAW'(TX_CAP - 1)) ? '0 : p + 1'b1;
  endfunction : tx_next
  function automatic logic [RAW-1:0] rx_next(input logic [RAW-1:0] p);
    return (p == RAW'(RX_CAP - 1)) ? '0 : p + 1'b1;
  endfunction : rx_next

  // Synchroniser stages and edge history
  link_in_t raw, s1_q, s2_q, s3_q;
  assign raw = '{lref: line_reference_clock, treq: tx_timing_marker_request,
                 rx_clk: link.rx_clk, rx_en_n: link.rx_en_n, rx_addr: link.rx_addr,
                 tx_clk: link.tx_clk, tx_en_n: link.tx_en_n, tx_soc: link.tx_soc,
                 tx_par: link.tx_parity, tx_addr: link.tx_addr, tx_data: link.tx_data};
  // Two flops before any logic, third only for edge finding
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  logic tx_rise, rx_rise, lref_rise, treq_fall, tx_sel, rx_sel;
  assign tx_rise   = s2_q.tx_clk & ~s3_q.tx_clk;
  assign rx_rise   = s2_q.rx_clk & ~s3_q.rx_clk;
  assign lref_rise = s2_q.lref & ~s3_q.lref;
  assign treq_fall = ~s2_q.treq & s3_q.treq;
  assign tx_sel    = (s2_q.tx_addr == port_addr);
  assign rx_sel    = (s2_q.rx_addr == port_addr);

  // Transmit store and its state
  byte_t           tx_mem [TX_CAP];      // Cell bytes awaiting the line
  logic [TAW-1:0]  tx_wp_q, tx_wp_d, tx_start_q, tx_start_d, tx_rp_q, tx_rp_d, tx_wa;
  idx_t            tx_widx_q, tx_widx_d, tx_ridx_q, tx_ridx_d;
  logic            tx_in_q, tx_in_d, tx_we, perr_ev, tx_soc_ev;
  logic [CW-1:0]   tx_full_q, tx_full_d;  // Complete cells not yet drained
  logic            mark_pend_q, mark_pend_d, tx_clav_q, tx_clav_d;
  byte_t           tl_data_q, tl_data_d;
  logic            tl_soc_q, tl_soc_d, tl_mark_q, tl_mark_d, tl_val_q, tl_val_d;
  logic            done, fin;

  // Transmit capture from the bus and drain toward the line
  always_comb begin
    tx_wp_d = tx_wp_q;
    tx_start_d = tx_start_q;
    tx_widx_d = tx_widx_q;
    tx_in_d = tx_in_q;
    tx_wa = tx_wp_q;
    tx_we = 1'b0;
    perr_ev = 1'b0;
    tx_soc_ev = 1'b0;
    done = 1'b0;
    fin = 1'b0;
    tx_rp_d = tx_rp_q;
    tx_ridx_d = tx_ridx_q;
    mark_pend_d = mark_pend_q | treq_fall;
    tl_data_d = tl_data_q;
    tl_soc_d = tl_soc_q;
    tl_mark_d = tl_mark_q;
    tl_val_d = tl_val_q;
    if (tx_rise && !s2_q.tx_en_n && tx_sel) begin
      perr_ev = (odd_par(s2_q.tx_data) != s2_q.tx_par);
      if (s2_q.tx_soc && (tx_in_q || tx_clav_q)) begin
        // A start mid-cell abandons the partial cell
        tx_wa = tx_in_q ? tx_start_q : tx_wp_q;
        tx_start_d = tx_wa;
        tx_wp_d = tx_next(tx_wa);
        tx_we = 1'b1;
        tx_in_d = 1'b1;
        tx_widx_d = idx_t'(1);
        tx_soc_ev = 1'b1;
      end else if (tx_in_q && !s2_q.tx_soc) begin
        tx_we = 1'b1;
        tx_wp_d = tx_next(tx_wp_q);
        tx_widx_d = tx_widx_q + 1'b1;
        if (tx_widx_q == LAST) begin
          tx_in_d = 1'b0;
          done = 1'b1;
        end
      end
    end
    if (!tl_val_q || tx_line_ready) begin
      tl_val_d = 1'b0;
      tl_soc_d = 1'b0;
      tl_mark_d = 1'b0;
      if (mark_pend_q) begin
        tl_val_d = 1'b1;
        tl_mark_d = 1'b1;
        tl_data_d = `MARKER_BYTE;
        mark_pend_d = treq_fall;
      end else if (tx_full_q != '0) begin
        tl_val_d = 1'b1;
        tl_data_d = tx_mem[tx_rp_q];
        tl_soc_d = (tx_ridx_q == '0);
        tx_rp_d = tx_next(tx_rp_q);
        tx_ridx_d = (tx_ridx_q == LAST) ? '0 : tx_ridx_q + 1'b1;
        fin = (tx_ridx_q == LAST);
      end
    end
    tx_full_d = tx_full_q + CW'(done) - CW'(fin);
    // Room for a whole cell beyond those held and in progress
    tx_clav_d = (tx_full_d + CW'(tx_in_d)) < CW'(TX_CELLS);
  end
  always_ff @(posedge core_clk) begin
    if (tx_we) begin
      tx_mem[tx_wa] <= s2_q.tx_data;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      tx_wp_q <= '0;
      tx_start_q <= '0;
      tx_rp_q <= '0;
      tx_widx_q <= '0;
      tx_ridx_q <= '0;
      tx_in_q <= 1'b0;
      tx_full_q <= '0;
      mark_pend_q <= 1'b0;
      tx_clav_q <= 1'b0;
      tl_data_q <= '0;
      tl_soc_q <= 1'b0;
      tl_mark_q <= 1'b0;
      tl_val_q <= 1'b0;
    end else begin
      tx_wp_q <= tx_wp_d;
      tx_start_q <= tx_start_d;
      tx_rp_q <= tx_rp_d;
      tx_widx_q <= tx_widx_d;
      tx_ridx_q <= tx_ridx_d;
      tx_in_q <= tx_in_d;
      tx_full_q <= tx_full_d;
      mark_pend_q <= mark_pend_d;
      tx_clav_q <= tx_clav_d;
      tl_data_q <= tl_data_d;
      tl_soc_q <= tl_soc_d;
      tl_mark_q <= tl_mark_d;
      tl_val_q <= tl_val_d;
    end
  end

  // Receive store and its state
  rx_entry_t       rx_mem [RX_CAP];      // Line cells awaiting the ATM layer
  logic [RAW-1:0]  rw_wp_q, rw_wp_d, rw_start_q, rw_start_d, rd_rp_q, rd_rp_d, rw_wa;
  idx_t            rw_idx_q, rw_idx_d, rd_idx_q, rd_idx_d;
  logic            rw_in_q, rw_in_d, rd_in_q, rd_in_d, rx_we, rw_done, rd_soc, rx_good_ev;
  logic [CW-1:0]   rx_full_q, rx_full_d;  // Complete cells not yet started
  rx_entry_t       rd_ent;
  byte_t           ro_data_q, ro_data_d;
  logic            ro_soc_q, ro_soc_d, ro_par_q, ro_par_d, rx_clav_q;

  // Receive fill from the line and read-out onto the bus
  always_comb begin
    rw_wp_d = rw_wp_q;
    rw_start_d = rw_start_q;
    rw_idx_d = rw_idx_q;
    rw_in_d = rw_in_q;
    rw_wa = rw_wp_q;
    rx_we = 1'b0;
    rw_done = 1'b0;
    rd_soc = 1'b0;
    rx_good_ev = 1'b0;
    rd_rp_d = rd_rp_q;
    rd_idx_d = rd_idx_q;
    rd_in_d = rd_in_q;
    rd_ent = rx_mem[rd_rp_q];
    ro_data_d = ro_data_q;
    ro_soc_d = ro_soc_q;
    ro_par_d = ro_par_q;
    if (rx_line_valid && rx_line_soc) begin
      // A cell with no room is dropped whole
      rw_in_d = (rx_full_q + CW'(rd_in_q)) < CW'(RX_CELLS);
      rw_wa = rw_in_q ? rw_start_q : rw_wp_q;
      rx_we = rw_in_d;
      if (rw_in_d) begin
        rw_start_d = rw_wa;
        rw_wp_d = rx_next(rw_wa);
        rw_idx_d = idx_t'(1);
      end
    end else if (rx_line_valid && rw_in_q) begin
      rx_we = 1'b1;
      rw_wp_d = rx_next(rw_wp_q);
      rw_idx_d = rw_idx_q + 1'b1;
      if (rw_idx_q == LAST) begin
        rw_in_d = 1'b0;
        rw_done = 1'b1;
      end
    end
    if (rx_rise && !s2_q.rx_en_n && rx_sel && (rd_in_q || rx_full_q != '0)) begin
      ro_data_d = rd_ent.data;
      ro_soc_d = (rd_idx_q == '0);
      ro_par_d = odd_par(rd_ent.data);
      rd_rp_d = rx_next(rd_rp_q);
      rd_soc = (rd_idx_q == '0);
      rx_good_ev = rd_soc && rd_ent.good;
      rd_in_d = (rd_idx_q != LAST);
      rd_idx_d = (rd_idx_q == LAST) ? '0 : rd_idx_q + 1'b1;
    end
    rx_full_d = rx_full_q + CW'(rw_done) - CW'(rd_soc);
  end
  always_ff @(posedge core_clk) begin
    if (rx_we) begin
      rx_mem[rw_wa] <= '{good: rx_line_soc & rx_line_good, data: rx_line_data};
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rw_wp_q <= '0;
      rw_start_q <= '0;
      rw_idx_q <= '0;
      rw_in_q <= 1'b0;
      rd_rp_q <= '0;
      rd_idx_q <= '0;
      rd_in_q <= 1'b0;
      rx_full_q <= '0;
      ro_data_q <= '0;
      ro_soc_q <= 1'b0;
      ro_par_q <= 1'b1;
      rx_clav_q <= 1'b0;
    end else begin
      rw_wp_q <= rw_wp_d;
      rw_start_q <= rw_start_d;
      rw_idx_q <= rw_idx_d;
      rw_in_q <= rw_in_d;
      rd_rp_q <= rd_rp_d;
      rd_idx_q <= rd_idx_d;
      rd_in_q <= rd_in_d;
      rx_full_q <= rx_full_d;
      ro_data_q <= ro_data_d;
      ro_soc_q <= ro_soc_d;
      ro_par_q <= ro_par_d;
      rx_clav_q <= (rx_full_d != '0);
    end
  end

  // Lamps, marker pulse and interrupt state
  logic [7:0] rl_cnt_q, rl_cnt_d, tl_cnt_q, tl_cnt_d, mk_cnt_q, mk_cnt_d;
  logic [1:0] irq_q, irq_d;
  logic       rl_q, tl_q, mk_n_q, irq_oe_n_q;
  always_comb begin
    // Lamp counts step on reference edges, not the core clock
    rl_cnt_d = rx_good_ev ? `LAMP_CYCLES :
               (lref_rise && rl_cnt_q != '0) ? rl_cnt_q - 1'b1 : rl_cnt_q;
    tl_cnt_d = tx_soc_ev ? `LAMP_CYCLES :
               (lref_rise && tl_cnt_q != '0) ? tl_cnt_q - 1'b1 : tl_cnt_q;
    mk_cnt_d = rx_line_marker ? marker_len :
               (mk_cnt_q != '0) ? mk_cnt_q - 1'b1 : mk_cnt_q;
    // Set beats the clear from a read in the same cycle
    irq_d = (irq_q & ~{2{status_read}}) | {rx_line_marker, perr_ev};
  end
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rl_cnt_q <= '0;
      tl_cnt_q <= '0;
      mk_cnt_q <= '0;
      irq_q <= '0;
      rl_q <= 1'b1;
      tl_q <= 1'b1;
      mk_n_q <= 1'b1;
      irq_oe_n_q <= 1'b1;
    end else begin
      rl_cnt_q <= rl_cnt_d;
      tl_cnt_q <= tl_cnt_d;
      mk_cnt_q <= mk_cnt_d;
      irq_q <= irq_d;
      rl_q <= (rl_cnt_d == '0);
      tl_q <= (tl_cnt_d == '0);
      mk_n_q <= (mk_cnt_d == '0);
      irq_oe_n_q <= ~(|(irq_d & irq_mask));
    end
  end

  // Output drive
  assign link.tx_clav      = tx_clav_q;
  assign link.tx_clav_oe_n = ~tx_sel;
  assign link.rx_clav      = rx_clav_q;
  assign link.rx_clav_oe_n = ~rx_sel;
  assign link.rx_data      = ro_data_q;
  assign link.rx_soc       = ro_soc_q;
  assign link.rx_parity    = ro_par_q;
  assign tx_line_data      = tl_data_q;
  assign tx_line_soc       = tl_soc_q;
  assign tx_line_marker    = tl_mark_q;
  assign tx_line_valid     = tl_val_q;
  assign irq_status        = irq_q;
  assign irq_o             = 1'b0;
  assign irq_oe_n          = irq_oe_n_q;
  assign rx_activity_lamp  = rl_q;
  assign tx_activity_lamp  = tl_q;
  assign rx_timing_marker_pulse_n = mk_n_q;
endmodule : phy_cell_end

// ---- core/atm_layer_end.sv ----
// ATM-layer end: makes the bus clocks, sends and collects cells
`include "atm_cell_params.svh"
module atm_layer_end #(
  parameter int HALF = `LINK_HALF_PERIOD
) (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rstn,
  // Cell bus toward the physical layer
  atm_cell_if.atm                    link,
  // Port to address
  input  wire atm_cell_pkg::port_t   port_sel,
  // User transmit side
  input  wire atm_cell_pkg::byte_t   user_tx_data,
  input  wire logic                  user_tx_soc,
  input  wire logic                  user_tx_valid,
  output logic                       user_tx_ready,
  // User receive side
  output atm_cell_pkg::byte_t        user_rx_data,
  output logic                       user_rx_soc,
  output logic                       user_rx_valid,
  output logic                       user_rx_parity_err,
  input  wire logic                  user_rx_ready
);
  import atm_cell_pkg::*;

  localparam idx_t LAST = idx_t'(`CELL_BYTES - 1);
  // Far end needs a few core cycles per phase; divider is eight bits wide
  if (HALF < 4 || HALF > 256) begin : g_bad_half
    $error("half period outside what the far end and the divider can serve");
  end

  // Free-running divider for both bus clocks
  logic [7:0] div_q, div_d;
  logic       lclk_q, lclk_d, fall, rise;
  always_comb begin
    fall = (div_q == 8'(HALF - 1)) && lclk_q;
    rise = (div_q == 8'(HALF - 1)) && !lclk_q;
    div_d = (div_q == 8'(HALF - 1)) ? '0 : div_q + 1'b1;
    lclk_d = lclk_q ^ (div_q == 8'(HALF - 1));
  end
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      div_q <= '0;
      lclk_q <= 1'b0;
    end else begin
      div_q <= div_d;
      lclk_q <= lclk_d;
    end
  end

  // Device outputs cross in through two flops
  phy_out_t raw, s1_q, s2_q;
  assign raw = '{tx_clav: link.tx_clav_line, rx_clav: link.rx_clav_line,
                 rx_soc: link.rx_soc, rx_par: link.rx_parity, rx_data: link.rx_data};
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end

  // Transmit sequencing and receive enable change on falling bus edges, receive data is taken on rising ones
  host_tx_state_t st_q, st_d;
  idx_t  tidx_q, tidx_d, ridx_q, ridx_d;
  byte_t td_q, td_d, ud_q, ud_d;
  logic  tsoc_q, tsoc_d, tpar_q, tpar_d, ten_n_q, ten_n_d, take, drive;
  logic  ren_n_q, ren_n_d, pend_q, pend_d, usoc_q, usoc_d, uval_q, uval_d, uperr_q, uperr_d;
  always_comb begin
    st_d = st_q;
    tidx_d = tidx_q;
    td_d = td_q;
    tsoc_d = tsoc_q;
    tpar_d = tpar_q;
    ten_n_d = ten_n_q;
    take = 1'b0;
    drive = 1'b0;
    if (fall) begin
      ten_n_d = 1'b1;
      if (user_tx_valid && user_tx_soc && (st_q == HT_CELL || s2_q.tx_clav)) begin
        take = 1'b1;
        drive = 1'b1;
        st_d = HT_CELL;
        tidx_d = idx_t'(1);
      end else if (user_tx_valid && !user_tx_soc) begin
        // Stray bytes outside a cell are taken and dropped
        take = 1'b1;
        drive = (st_q == HT_CELL);
        tidx_d = tidx_q + 1'b1;
        if (st_q == HT_CELL && tidx_q == LAST) begin
          st_d = HT_IDLE;
        end
      end
      if (drive) begin
        td_d = user_tx_data;
        tsoc_d = user_tx_soc;
        tpar_d = odd_par(user_tx_data);
        ten_n_d = 1'b0;
      end
    end
    ren_n_d = ren_n_q;
    ridx_d = ridx_q;
    pend_d = pend_q;
    ud_d = ud_q;
    usoc_d = usoc_q;
    uperr_d = uperr_q;
    uval_d = 1'b0;
    if (fall) begin
      ren_n_d = ~(user_rx_ready && (ridx_q != '0 || s2_q.rx_clav));
    end
    if (rise) begin
      pend_d = ~ren_n_q;
      if (!ren_n_q) begin
        ridx_d = (ridx_q == LAST) ? '0 : ridx_q + 1'b1;
      end
      if (pend_q) begin
        uval_d = 1'b1;
        ud_d = s2_q.rx_data;
        usoc_d = s2_q.rx_soc;
        uperr_d = (odd_par(s2_q.rx_data) != s2_q.rx_par);
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st_q <= HT_IDLE;
      tidx_q <= '0;
      td_q <= '0;
      tsoc_q <= 1'b0;
      tpar_q <= 1'b1;
      ten_n_q <= 1'b1;
      ren_n_q <= 1'b1;
      ridx_q <= '0;
      pend_q <= 1'b0;
      ud_q <= '0;
      usoc_q <= 1'b0;
      uval_q <= 1'b0;
      uperr_q <= 1'b0;
    end else begin
      st_q <= st_d;
      tidx_q <= tidx_d;
      td_q <= td_d;
      tsoc_q <= tsoc_d;
      tpar_q <= tpar_d;
      ten_n_q <= ten_n_d;
      ren_n_q <= ren_n_d;
      ridx_q <= ridx_d;
      pend_q <= pend_d;
      ud_q <= ud_d;
      usoc_q <= usoc_d;
      uval_q <= uval_d;
      uperr_q <= uperr_d;
    end
  end

  // Clocks run from reset onward, never gated
  assign link.tx_clk    = lclk_q;
  assign link.rx_clk    = lclk_q;
  assign link.tx_addr   = port_sel;
  assign link.rx_addr   = port_sel;
  assign link.tx_data   = td_q;
  assign link.tx_soc    = tsoc_q;
  assign link.tx_parity = tpar_q;
  assign link.tx_en_n   = ten_n_q;
  assign link.rx_en_n   = ren_n_q;
  assign user_tx_ready  = take;
  assign user_rx_data   = ud_q;
  assign user_rx_soc    = usoc_q;
  assign user_rx_valid  = uval_q;
  assign user_rx_parity_err = uperr_q;
endmodule : atm_layer_end

// ---- verification/atm_cell_chk.sv ----
// Assertions on the cell bus between the two ends
module atm_cell_chk (
  // Clock, reset, own port address
  input wire logic                core_clk,
  input wire logic                rstn,
  input wire atm_cell_pkg::port_t port_addr,
  // Bus signals
  input wire atm_cell_pkg::port_t tx_addr,
  input wire atm_cell_pkg::port_t rx_addr,
  input wire logic                tx_clav_oe_n,
  input wire logic                rx_clav_oe_n,
  input wire atm_cell_pkg::byte_t rx_data,
  input wire logic                rx_soc,
  input wire logic                rx_parity,
  input wire logic                rx_en_n
);
  timeunit 1ns;
  timeprecision 1ps;
  import atm_cell_pkg::*;
  // Address match passes two sync stages, hence four samples
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  AST_RX_PARITY:
    assert property (rx_parity == ~(^rx_data)) else $error("rx parity even");
  AST_TX_FLOAT:
    assert property ((tx_addr != port_addr)[*4] |-> tx_clav_oe_n) else $error("tx clav driven");
  AST_RX_FLOAT:
    assert property ((rx_addr != port_addr)[*4] |-> rx_clav_oe_n) else $error("rx clav driven");
  AST_TX_DRIVE:
    assert property ((tx_addr == port_addr)[*4] |-> !tx_clav_oe_n) else $error("tx clav float");
  AST_RX_DRIVE:
    assert property ((rx_addr == port_addr)[*4] |-> !rx_clav_oe_n) else $error("rx clav float");
  AST_RX_POP_EN:
    assert property ($changed(rx_data) |-> !rx_en_n) else $error("rx data moved unenabled");
  AST_SOC_EN:
    assert property ($changed(rx_soc) |-> !rx_en_n) else $error("rx soc moved unenabled");
  AST_SOC_HOLD:
    assert property ($rose(rx_soc) |-> rx_soc[*8]) else $error("rx soc too short");
endmodule : atm_cell_chk

// ---- verification/atm_phy_cell_bus_and_status_pins_bench.sv ----
// Bench joining both cell bus ends, with line side stimulus
`include "atm_cell_params.svh"
module atm_phy_cell_bus_and_status_pins_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import atm_cell_pkg::*;
  logic core_clk = 1'h0, rstn = 1'h0, lref = 1'h0, treq = 1'h1, sr = 1'h0, tlr = 1'h0;
  logic rlv = 1'h0, rls = 1'h0, rlg = 1'h1, rlm = 1'h0, uts = 1'h0, utv = 1'h0, urr = 1'h0;
  logic [1:0] mask = 2'h2, irq_st;
  logic [7:0] mlen = 8'h05;  // Marker pulse length, varied per pass
  port_t psel = 5'h03;  // Matches the device address
  byte_t rld = 8'h00, utd = 8'h00, tld, urd;
  logic irq_o, irq_oe_n, tls, tlm, tlv, rlamp, tlamp, mpn, utr, urs, urv, upe;
  int error_cnt = 0, check_count = 0;
  atm_cell_if ifc ();
  phy_cell_end u_phy_cell_end (.core_clk(core_clk), .rstn(rstn), .link(ifc.phy),
    .port_addr(5'h03), .irq_mask(mask), .status_read(sr), .marker_len(mlen),
    .irq_status(irq_st), .irq_o(irq_o), .irq_oe_n(irq_oe_n), .tx_line_data(tld),
    .tx_line_soc(tls), .tx_line_marker(tlm), .tx_line_valid(tlv), .tx_line_ready(tlr),
    .rx_line_data(rld), .rx_line_soc(rls), .rx_line_valid(rlv), .rx_line_good(rlg),
    .rx_line_marker(rlm), .line_reference_clock(lref), .tx_timing_marker_request(treq),
    .rx_activity_lamp(rlamp), .tx_activity_lamp(tlamp), .rx_timing_marker_pulse_n(mpn));
  atm_layer_end u_atm_layer_end (.core_clk(core_clk), .rstn(rstn), .link(ifc.atm),
    .port_sel(psel), .user_tx_data(utd), .user_tx_soc(uts), .user_tx_valid(utv),
    .user_tx_ready(utr), .user_rx_data(urd), .user_rx_soc(urs), .user_rx_valid(urv),
    .user_rx_parity_err(upe), .user_rx_ready(urr));
  atm_cell_chk u_atm_cell_chk (.core_clk(core_clk), .rstn(rstn), .port_addr(5'h03),
    .tx_addr(ifc.tx_addr), .rx_addr(ifc.rx_addr), .tx_clav_oe_n(ifc.tx_clav_oe_n),
    .rx_clav_oe_n(ifc.rx_clav_oe_n), .rx_data(ifc.rx_data), .rx_soc(ifc.rx_soc),
    .rx_parity(ifc.rx_parity), .rx_en_n(ifc.rx_en_n));
  initial forever #5 core_clk = ~core_clk;
  // Reference at 32 MHz, offset so its edges never meet a core clock edge
  initial begin
    #2;
    forever #15.625 lref = ~lref;
  end
  task report_and_stop();
    if (error_cnt == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  task chk(input string n, input byte_t e, input byte_t g);
    check_count++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask : chk
  // Waits at least one edge, so a one-cycle pulse is never counted twice
  task automatic wt(input int w, input logic v);
    int k;
    logic s;
    k = 0;
    do begin
      @(posedge core_clk);
      #1;
      k++;
      s = (w == 0) ? urv : (w == 1) ? utr : (w == 2) ? tlv : tlm;
    end while (s !== v && k < 4000);
    if (s !== v) begin
      error_cnt++;
      report_and_stop();
    end
  endtask : wt
  initial begin
    repeat (8) @(posedge core_clk);
    rstn <= 1'h1;
    repeat (40) @(posedge core_clk);
    #1;
    chk("tx_clav", 8'h1, ifc.tx_clav_line);
    chk("rx_clav", 8'h0, ifc.rx_clav_line);
    @(posedge core_clk);
    psel <= 5'h09;
    repeat (40) @(posedge core_clk);
    #1;
    chk("tx_oe", 8'h1, ifc.tx_clav_oe_n);
    chk("rx_oe", 8'h1, ifc.rx_clav_oe_n);
    @(posedge core_clk);
    psel <= 5'h03;
    // One cell out while the line stalls
    for (int i = 0; i < `CELL_BYTES; i++) begin
      @(posedge core_clk);
      utd <= byte_t'(i * 7 + 17);
      uts <= (i == 0);
      utv <= 1'h1;
      wt(1, 1'h1);
      if (i == 1) chk("tx_lamp", 8'h0, tlamp);
    end
    @(posedge core_clk);
    utv <= 1'h0;
    tlr <= 1'h1;
    for (int i = 0; i < `CELL_BYTES; i++) begin
      wt(2, 1'h1);
      chk("tx_line", byte_t'(i * 7 + 17), tld);
      chk("tx_soc", i == 0, tls);
    end
    chk("par_err", 8'h0, irq_st);
    // One good cell in from the line
    for (int i = 0; i <= `CELL_BYTES; i++) begin
      @(posedge core_clk);
      rld <= ~byte_t'(i * 7 + 17);
      rls <= (i == 0);
      rlv <= (i < `CELL_BYTES);
    end
    repeat (40) @(posedge core_clk);
    #1;
    chk("rx_clav", 8'h1, ifc.rx_clav_line);
    @(posedge core_clk);
    urr <= 1'h1;
    for (int i = 0; i < `CELL_BYTES; i++) begin
      wt(0, 1'h1);
      chk("rx_data", ~byte_t'(i * 7 + 17), urd);
      chk("rx_soc", i == 0, urs);
      chk("rx_par", 8'h0, upe);
      if (i == 0) chk("rx_lamp", 8'h0, rlamp);
    end
    // Received marker, pin unmasked then masked
    for (int m = 0; m < 2; m++) begin
      @(posedge core_clk);
      mask <= m ? 2'h0 : 2'h2;
      // Shorter pulse on the masked pass shows the length input is used
      mlen <= m ? 8'h03 : 8'h05;
      rlm <= 1'h1;
      @(posedge core_clk);
      rlm <= 1'h0;
      repeat (3) @(posedge core_clk);
      #1;
      chk("mpulse", byte_t'(m), mpn);
      chk("irq_pin", byte_t'(m), irq_oe_n);
      chk("irq_o", 8'h0, irq_o);
      repeat (6) @(posedge core_clk);
      #1;
      chk("mpulse_end", 8'h1, mpn);
      chk("irq_hold", byte_t'(m), irq_oe_n);
      chk("irq_status", 8'h2, irq_st);
      @(posedge core_clk);
      sr <= 1'h1;
      @(posedge core_clk);
      sr <= 1'h0;
      repeat (3) @(posedge core_clk);
      #1;
      chk("irq_clr", 8'h1, irq_oe_n);
    end
    @(posedge core_clk);
    treq <= 1'h0;
    wt(3, 1'h1);
    chk("marker", `MARKER_BYTE, tld);
    report_and_stop();
  end
endmodule : atm_phy_cell_bus_and_status_pins_bench
